// ==== tw_pkg.sv ====
package tw_pkg;
	localparam logic [7:0] ADDR_PART_ID = 8'h00;
	localparam logic [7:0] ADDR_REV_ID = 8'h01;
	localparam logic [7:0] ADDR_FLASH_CTL = 8'h02;
	localparam logic [7:0] ADDR_FLASH_DAT = 8'hAD;
	localparam logic [7:0] READ_NONE = 8'h00;
	localparam logic [7:0] SELECT_RESET = 8'h00;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	localparam logic [7:0] CMD_BLOCK_READ = 8'h06;
	localparam logic [7:0] CMD_BLOCK_WRITE = 8'h07;
	localparam logic [7:0] CMD_PAGE_ERASE = 8'h08;
	localparam logic [7:0] CMD_DEVICE_ERASE = 8'h03;

	// instruction field, shifted in lsb first after the start bit
	localparam logic [1:0] INS_DATA_READ = 2'h0;
	localparam logic [1:0] INS_ADDR_WRITE = 2'h1;
	localparam logic [1:0] INS_DATA_WRITE = 2'h2;
	localparam logic [1:0] INS_ADDR_READ = 2'h3;

	localparam logic [3:0] INS_LAST_BIT = 4'h1;
	localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
	localparam logic [3:0] COUNT_ZERO = 4'h0;
	localparam logic [3:0] COUNT_STEP = 4'h1;

	typedef enum logic [1:0] {
		FLASH_OP_READ,
		FLASH_OP_WRITE,
		FLASH_OP_PAGE_ERASE,
		FLASH_OP_DEVICE_ERASE
	} tw_flash_op_t;

	typedef enum {
		LINK_IDLE,
		LINK_INSTR,
		LINK_WDATA,
		LINK_RDATA,
		LINK_RELEASE
	} tw_link_state_t;
endpackage : tw_pkg

// ==== tw_debug_regs.sv ====
`timescale 1ns/100ps
module tw_debug_regs
	import tw_pkg::*;
#(
	// arbitrary values, not tied to any real part
	parameter logic [7:0] PART_ID = 8'hA5,
	parameter logic [7:0] REV_ID = 8'h01
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic halted,
	input wire logic debugLinkClock,
	input wire logic sharedPinIn,
	input wire logic userPortOut,
	input wire logic userPortOe,
	input wire logic [7:0] flashReadData,
	input wire logic flashDone,
	output logic sharedPinOut,
	output logic sharedPinOe,
	output logic resetRequest,
	output logic [7:0] flashControl,
	output logic [7:0] flashWriteData,
	output logic flashByteStrobe,
	output logic flashReadStrobe,
	output logic flashCmdStrobe,
	output tw_flash_op_t flashCmd
);
	logic clkSync1;
	logic clkSync2;
	logic clkPrev;
	logic datSync1;
	logic datSync2;
	tw_link_state_t state;
	logic [3:0] bitCount;
	logic [1:0] instr;
	logic [7:0] shiftIn;
	logic [7:0] shiftOut;
	logic linkBit;
	logic linkOe;
	logic [7:0] selectReg;
	logic expectCommand;

	// only the second stages and clkPrev feed logic
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// link clock idles high; a low reset value would fake a rise
			clkSync1 <= 1'b1;
			clkSync2 <= 1'b1;
			clkPrev <= 1'b1;
			datSync1 <= 1'b0;
			datSync2 <= 1'b0;
		end else begin
			clkSync1 <= debugLinkClock;
			clkSync2 <= clkSync1;
			clkPrev <= clkSync2;
			datSync1 <= sharedPinIn;
			datSync2 <= datSync1;
		end
	end

	// edges only count while halted
	wire linkRise = halted & clkSync2 & ~clkPrev;
	wire linkFall = halted & ~clkSync2 & clkPrev;

	wire [1:0] nextInstr = {datSync2, instr[1]};
	wire [7:0] writeByte = {datSync2, shiftIn[7:1]};
	wire instrDone = (state == LINK_INSTR) & linkRise &
		(bitCount == INS_LAST_BIT);
	wire instrIsRead = (nextInstr == INS_DATA_READ) |
		(nextInstr == INS_ADDR_READ);
	wire readStart = instrDone & instrIsRead;
	wire writeDone = (state == LINK_WDATA) & linkRise &
		(bitCount == BYTE_LAST_BIT);
	wire addrWrite = writeDone & (instr == INS_ADDR_WRITE);
	wire dataWrite = writeDone & (instr == INS_DATA_WRITE);

	wire selPart = selectReg == ADDR_PART_ID;
	wire selRev = selectReg == ADDR_REV_ID;
	wire selCtl = selectReg == ADDR_FLASH_CTL;
	wire selDat = selectReg == ADDR_FLASH_DAT;

	wire [7:0] dataReadValue = selPart ? PART_ID :
		selRev ? REV_ID :
		selCtl ? flashControl :
		selDat ? flashReadData :
		READ_NONE;
	wire [7:0] readValue = (nextInstr == INS_ADDR_READ) ? selectReg :
		dataReadValue;

	wire cmdRead = writeByte == CMD_BLOCK_READ;
	wire cmdWrite = writeByte == CMD_BLOCK_WRITE;
	wire cmdPage = writeByte == CMD_PAGE_ERASE;
	wire cmdAll = writeByte == CMD_DEVICE_ERASE;
	wire cmdValid = cmdRead | cmdWrite | cmdPage | cmdAll;
	wire datWrite = dataWrite & selDat;
	wire cmdTake = datWrite & expectCommand & cmdValid;
	wire byteTake = datWrite & ~expectCommand;
	wire tw_flash_op_t cmdOp = cmdRead ? FLASH_OP_READ :
		cmdWrite ? FLASH_OP_WRITE :
		cmdPage ? FLASH_OP_PAGE_ERASE : FLASH_OP_DEVICE_ERASE;

	// leaving halt drops any half frame; the host must restart
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= LINK_IDLE;
			bitCount <= COUNT_ZERO;
		end else if (!halted) begin
			state <= LINK_IDLE;
			bitCount <= COUNT_ZERO;
		end else begin
			case (state)
				LINK_IDLE: begin
					if (linkRise && datSync2) begin
						state <= LINK_INSTR;
						bitCount <= COUNT_ZERO;
					end
				end
				LINK_INSTR: begin
					if (linkRise) begin
						bitCount <= bitCount + COUNT_STEP;
						if (instrDone) begin
							bitCount <= COUNT_ZERO;
							state <= instrIsRead ? LINK_RDATA : LINK_WDATA;
						end
					end
				end
				LINK_WDATA: begin
					if (linkRise) begin
						bitCount <= bitCount + COUNT_STEP;
						if (writeDone) begin
							state <= LINK_IDLE;
						end
					end
				end
				LINK_RDATA: begin
					if (linkRise) begin
						bitCount <= bitCount + COUNT_STEP;
						if (bitCount == BYTE_LAST_BIT) begin
							state <= LINK_RELEASE;
						end
					end
				end
				LINK_RELEASE: begin
					if (linkFall) begin
						state <= LINK_IDLE;
					end
				end
				default: begin
					state <= LINK_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			instr <= INS_DATA_READ;
			shiftIn <= BYTE_RESET;
		end else begin
			if ((state == LINK_INSTR) && linkRise) begin
				instr <= nextInstr;
			end
			if ((state == LINK_WDATA) && linkRise) begin
				shiftIn <= writeByte;
			end
		end
	end

	// device drives on falling edges so the host samples on rising ones
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shiftOut <= BYTE_RESET;
			linkBit <= 1'b0;
			linkOe <= 1'b0;
		end else if (!halted) begin
			linkOe <= 1'b0;
		end else if (readStart) begin
			shiftOut <= readValue;
		end else if (linkFall && (state == LINK_RDATA)) begin
			linkBit <= shiftOut[0];
			shiftOut <= {1'b0, shiftOut[7:1]};
			linkOe <= 1'b1;
		end else if (linkFall && (state == LINK_RELEASE)) begin
			linkOe <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			selectReg <= SELECT_RESET;
			flashControl <= CONTROL_RESET;
		end else begin
			if (addrWrite) begin
				selectReg <= writeByte;
			end
			if (dataWrite && selCtl) begin
				flashControl <= writeByte;
			end
		end
	end

	// a stray non-command byte raises no strobe, though flashWriteData still takes it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			expectCommand <= 1'b1;
			flashWriteData <= BYTE_RESET;
			flashByteStrobe <= 1'b0;
			flashCmdStrobe <= 1'b0;
			flashCmd <= FLASH_OP_READ;
			flashReadStrobe <= 1'b0;
		end else begin
			flashByteStrobe <= byteTake;
			flashCmdStrobe <= cmdTake;
			flashReadStrobe <= readStart & (nextInstr == INS_DATA_READ) &
				selDat;
			if (datWrite) begin
				flashWriteData <= writeByte;
			end
			if (cmdTake) begin
				flashCmd <= cmdOp;
			end
			if (flashDone) begin
				expectCommand <= 1'b1;
			end else if (cmdTake) begin
				expectCommand <= 1'b0;
			end
		end
	end

	// pins borrowed only while halted
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sharedPinOut <= 1'b0;
			sharedPinOe <= 1'b0;
			resetRequest <= 1'b0;
		end else begin
			sharedPinOut <= halted ? linkBit : userPortOut;
			sharedPinOe <= halted ? linkOe : userPortOe;
			resetRequest <= ~halted & ~clkSync2;
		end
	end
endmodule : tw_debug_regs

// ==== tw_debug_regs_asserts.sv ====
`timescale 1ns/100ps
module tw_debug_regs_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic halted,
	input wire logic userPortOut,
	input wire logic userPortOe,
	input wire logic sharedPinOut,
	input wire logic sharedPinOe,
	input wire logic resetRequest,
	input wire logic [7:0] flashControl,
	input wire logic flashByteStrobe,
	input wire logic flashCmdStrobe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence freeRun;
		!halted ##1 !halted;
	endsequence
	user_oe_a: assert property (freeRun |-> sharedPinOe == $past(userPortOe))
		else $error("pin enable not from user");
	user_out_a: assert property (freeRun |-> sharedPinOut == $past(userPortOut))
		else $error("pin value not from user");
	reset_req_a: assert property (resetRequest |-> !$past(halted))
		else $error("reset request while halted");
	cmd_pulse_a: assert property (flashCmdStrobe |=> !flashCmdStrobe)
		else $error("command strobe too long");
	strobe_excl_a: assert property (flashCmdStrobe |-> !flashByteStrobe)
		else $error("command and byte together");
	ctl_halt_a: assert property ($changed(flashControl) |-> $past(halted))
		else $error("control changed while running");
	byte_halt_a: assert property (flashByteStrobe |-> $past(halted))
		else $error("byte strobe while running");
	cmd_halt_a: assert property (flashCmdStrobe |-> $past(halted))
		else $error("command strobe while running");
endmodule : tw_debug_regs_chk

bind tw_debug_regs tw_debug_regs_chk chk_u (.clk(clk), .rst_n(rst_n),
	.halted(halted), .userPortOut(userPortOut), .userPortOe(userPortOe),
	.sharedPinOut(sharedPinOut), .sharedPinOe(sharedPinOe),
	.resetRequest(resetRequest), .flashControl(flashControl),
	.flashByteStrobe(flashByteStrobe), .flashCmdStrobe(flashCmdStrobe));

// ==== tw_host_model.sv ====
`timescale 1ns/100ps
module tw_host_model (
	output logic debugLinkClock,
	output logic hostData,
	input wire logic linkPin
);
	// clock idles high: low would read as a reset request
	initial begin
		debugLinkClock = 1'b1;
		hostData = 1'b0;
	end
	task automatic send_bit(input logic b);
		debugLinkClock = 1'b0;
		hostData = b;
		#62.5 debugLinkClock = 1'b1;
		#62.5;
	endtask : send_bit
	task automatic frame(input logic [1:0] ins, input logic [7:0] wr,
		output logic [7:0] rd);
		rd = 8'h00;
		send_bit(1'b1);
		send_bit(ins[0]);
		send_bit(ins[1]);
		if (ins[0] ^ ins[1]) begin
			for (int i = 0; i < 8; i++) send_bit(wr[i]);
		end else begin
			// released: show the inverse, never a kept value
			hostData = ~ins[1];
			for (int i = 0; i < 8; i++) begin
				debugLinkClock = 1'b0;
				#62.5 debugLinkClock = 1'b1;
				rd[i] = linkPin;
				#62.5;
			end
			send_bit(1'b0);
		end
	endtask : frame
endmodule : tw_host_model

// ==== testbench.sv ====
`timescale 1ns/100ps
module testbench;
	import tw_pkg::*;
	localparam logic [7:0] PART = 8'h5C; // arbitrary
	localparam logic [7:0] REV = 8'h02; // arbitrary
	logic clk, rst_n, halted, userPortOut, userPortOe, flashDone, linkPin;
	logic sharedPinOut, sharedPinOe, resetRequest, flashByteStrobe;
	logic flashReadStrobe, flashCmdStrobe, debugLinkClock, hostData;
	logic [7:0] flashReadData, flashControl, flashWriteData, rd;
	logic [7:0] cmds[4] = '{CMD_BLOCK_READ, CMD_BLOCK_WRITE,
		CMD_PAGE_ERASE, CMD_DEVICE_ERASE};
	tw_flash_op_t flashCmd, lastCmd;
	int miscompares = 0, checked = 0, cmdCount = 0;
	int readCount = 0, byteCount = 0, resetSeen = 0;
	assign linkPin = sharedPinOe ? sharedPinOut : hostData;
	tw_debug_regs #(.PART_ID(PART), .REV_ID(REV)) dut_u (.clk(clk),
		.rst_n(rst_n), .halted(halted), .debugLinkClock(debugLinkClock),
		.sharedPinIn(linkPin), .userPortOut(userPortOut),
		.userPortOe(userPortOe), .flashReadData(flashReadData),
		.flashDone(flashDone), .sharedPinOut(sharedPinOut),
		.sharedPinOe(sharedPinOe), .resetRequest(resetRequest),
		.flashControl(flashControl), .flashWriteData(flashWriteData),
		.flashByteStrobe(flashByteStrobe), .flashReadStrobe(flashReadStrobe),
		.flashCmdStrobe(flashCmdStrobe), .flashCmd(flashCmd));
	tw_host_model host_u (.debugLinkClock(debugLinkClock),
		.hostData(hostData), .linkPin(linkPin));
	always @(posedge clk) begin
		if (flashCmdStrobe === 1'b1) begin
			lastCmd <= flashCmd;
			cmdCount++;
		end
		if (flashReadStrobe === 1'b1) begin
			readCount++;
		end
		if (flashByteStrobe === 1'b1) begin
			byteCount++;
		end
		if (resetRequest === 1'b1) begin
			resetSeen = 1;
		end
	end
	task automatic close_out;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out
	task automatic check(input string w, input logic [7:0] s, e);
		checked++;
		if (s !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", w, e, s);
		end
	endtask : check
	task automatic dat_wr(input logic [7:0] a, d);
		host_u.frame(INS_ADDR_WRITE, a, rd);
		host_u.frame(INS_DATA_WRITE, d, rd);
	endtask : dat_wr
	task automatic dat_rd(input logic [7:0] a);
		host_u.frame(INS_ADDR_WRITE, a, rd);
		host_u.frame(INS_DATA_READ, 8'h00, rd);
	endtask : dat_rd
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#300us;
		miscompares++;
		close_out;
	end
	initial begin
		rst_n = 1'b0;
		halted = 1'b1;
		userPortOut = 1'b0;
		userPortOe = 1'b0;
		flashDone = 1'b0;
		flashReadData = 8'h00;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk);
		dat_rd(ADDR_PART_ID);
		check("part", rd, PART);
		dat_wr(ADDR_REV_ID, 8'h5A);
		dat_rd(ADDR_REV_ID);
		check("rev", rd, REV);
		host_u.frame(INS_ADDR_READ, 8'h00, rd);
		check("select", rd, ADDR_REV_ID);
		dat_wr(ADDR_FLASH_CTL, 8'hC3);
		dat_rd(ADDR_FLASH_CTL);
		check("control", rd, 8'hC3);
		check("control pins", flashControl, 8'hC3);
		dat_wr(8'h55, 8'h11);
		dat_rd(8'h55);
		check("unlisted", rd, 8'h00);
		dat_wr(ADDR_FLASH_DAT, 8'h42);
		for (int i = 0; i < 4; i++) begin
			dat_wr(ADDR_FLASH_DAT, cmds[i]);
			repeat (8) @(posedge clk);
			check("command", {6'h00, lastCmd}, i[7:0]);
			flashDone <= 1'b1;
			@(posedge clk) flashDone <= 1'b0;
		end
		check("commands", cmdCount[7:0], 8'h04);
		dat_wr(ADDR_FLASH_DAT, CMD_BLOCK_WRITE);
		host_u.frame(INS_DATA_WRITE, 8'h3C, rd);
		repeat (8) @(posedge clk);
		check("byte", flashWriteData, 8'h3C);
		check("byte strobes", byteCount[7:0], 8'h01);
		@(posedge clk) flashReadData <= 8'h96;
		dat_rd(ADDR_FLASH_DAT);
		check("flash read", rd, 8'h96);
		check("read strobes", readCount[7:0], 8'h01);
		host_u.frame(INS_ADDR_WRITE, ADDR_FLASH_CTL, rd);
		check("no reset", resetSeen[7:0], 8'h00);
		@(posedge clk) halted <= 1'b0;
		userPortOe <= 1'b1;
		userPortOut <= 1'b1;
		repeat (3) @(posedge clk);
		check("user pin", {sharedPinOe, sharedPinOut}, 8'h03);
		host_u.frame(INS_DATA_WRITE, 8'h00, rd);
		check("reset pin", resetSeen[7:0], 8'h01);
		@(posedge clk) userPortOe <= 1'b0;
		halted <= 1'b1;
		repeat (5) @(posedge clk);
		check("control kept", flashControl, 8'hC3);
		close_out;
	end
endmodule : testbench
